// File: verilog/tls_torque_limit_selector.sv
// Torque limit selector: picks active forward and reverse torque limits
//
// Function
// - Analog-only mode: each limit is the smaller of analog command and internal limit.
// - Linear motor takes internal limits from the linear-motor settings.
// - Source value 1 selects the analog command as limit, effective after a setup restart (apply write).
// - Source value 3 uses analog limit only while an external-limit input is on.
// - Rotary, combined, forward input on: minimum of analog, internal and external forward.
// - Rotary, forward input off: internal forward limit only.
// - Rotary, combined, reverse input on: minimum of analog, internal and external reverse.
// - Rotary, reverse input off: internal reverse limit only.
// - Linear, forward input on: minimum of analog, linear forward and external forward.
// - Linear, forward input off: linear internal forward limit only.
// - Linear, reverse input on: minimum of analog, linear reverse and external reverse.
// - Linear, reverse input off: linear internal reverse limit only.
// - No analog limiting in torque control mode; the input carries the command.
// - Command input gain 10 to 100, default 30, units of 0.1 V.
// - Internal limits 0 to 800 percent, default 800; linear-motor internal limits default 30.
// - Analog command low-pass filter, time constant 0 to 65535 times 0.01 ms.
// - External-limit inputs can be moved to other pins by allocation fields.
// - Limit-detected output asserts whenever torque is being limited.
// - External limits 0 to 800 percent, default 100.
`timescale 1ns/100ps
`include "tls_params.svh"

module tls_torque_limit_selector (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // Register port
  input  wire logic [3:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  // Digital input pins, external-limit inputs among them
  input  wire logic [`TLS_PIN_COUNT-1:0]   input_pins,
  // Analog command from the converter, millivolts, mclk domain
  input  wire logic signed [15:0]          analog_cmd,
  // Present motor torque and its direction
  input  wire tls_pkg::tls_pct_t           torque_fb_pct,
  input  wire logic                        torque_fb_rev,
  // Results
  output tls_pkg::tls_limit_pair_t         active_limits,
  output logic                             limit_detected_output
);
  import tls_pkg::*;

  tls_src_t                   src_pend;
  tls_src_t                   src_act;
  logic                       cfg_linear;
  logic                       cfg_tq;
  logic [6:0]                 gain;
  tls_pct_t                   int_fwd;
  tls_pct_t                   int_rev;
  tls_pct_t                   ext_fwd;
  tls_pct_t                   ext_rev;
  tls_pct_t                   lin_fwd;
  tls_pct_t                   lin_rev;
  logic [15:0]                filt_tc;
  logic [15:0]                pin_alloc;
  logic [`TLS_PIN_COUNT-1:0]  pins_s;
  logic signed [15:0]         analog_q;
  logic signed [15:0]         filtered;
  logic [15:0]                abs_mv;
  logic [15:0]                quot;
  tls_pct_t                   ana_pct;
  logic                       ana_ok;
  logic                       fwd_on;
  logic                       rev_on;
  tls_pct_t                   sel_fwd;
  tls_pct_t                   sel_rev;
  tls_limit_pair_t            next_limits;
  logic                       next_detected;
  logic [3:0]                 fwd_pin;
  logic [3:0]                 rev_pin;

  // Saturate a written limit to the 800 percent ceiling
  function automatic tls_pct_t tls_sat(input logic [31:0] v);
    tls_sat = (v > 32'(`TLS_PCT_MAX)) ? `TLS_PCT_MAX : v[9:0];
  endfunction : tls_sat

  function automatic tls_pct_t tls_min(input tls_pct_t a, input tls_pct_t b);
    tls_min = (a < b) ? a : b;
  endfunction : tls_min

  // Limit of one direction from source, its input and the three candidates
  function automatic tls_pct_t tls_pick(input tls_src_t src, input logic on,
                                        input logic ok, input tls_pct_t lim_int,
                                        input tls_pct_t lim_ext, input tls_pct_t ana);
    tls_pct_t with_ext;
    with_ext = tls_min(lim_int, lim_ext);
    tls_pick = lim_int;
    unique case (src)
      TLS_SRC_INTERNAL: begin
        if (on) tls_pick = with_ext;
      end
      TLS_SRC_ANALOG: begin
        if (ok) tls_pick = tls_min(lim_int, ana);
      end
      TLS_SRC_RESERVED: begin
        tls_pick = lim_int;
      end
      TLS_SRC_ANALOG_EXT: begin
        if (on && ok) tls_pick = tls_min(with_ext, ana);
        else if (on)  tls_pick = with_ext;
      end
    endcase
  endfunction : tls_pick

  // Parameter writes; limits act at once, with range clamping
  always_ff @(posedge mclk) begin
    if (rst) begin
      src_pend   <= TLS_SRC_INTERNAL;
      cfg_linear <= 1'b0;
      cfg_tq     <= 1'b0;
      gain       <= `TLS_GAIN_RST;
      int_fwd    <= `TLS_INT_LIMIT_RST;
      int_rev    <= `TLS_INT_LIMIT_RST;
      ext_fwd    <= `TLS_EXT_LIMIT_RST;
      ext_rev    <= `TLS_EXT_LIMIT_RST;
      lin_fwd    <= `TLS_LIN_LIMIT_RST;
      lin_rev    <= `TLS_LIN_LIMIT_RST;
      filt_tc    <= `TLS_TC_RST;
      pin_alloc  <= `TLS_PIN_ALLOC_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `TLS_ADDR_SRC_SEL: src_pend <= tls_src_t'(reg_wdata[1:0]);
        `TLS_ADDR_CFG: begin
          cfg_linear <= reg_wdata[`TLS_CFG_LINEAR_BIT];
          cfg_tq     <= reg_wdata[`TLS_CFG_TQMODE_BIT];
        end
        `TLS_ADDR_GAIN: begin
          if (reg_wdata < 32'(`TLS_GAIN_MIN))      gain <= `TLS_GAIN_MIN;
          else if (reg_wdata > 32'(`TLS_GAIN_MAX)) gain <= `TLS_GAIN_MAX;
          else                                     gain <= reg_wdata[6:0];
        end
        `TLS_ADDR_INT_FWD:   int_fwd   <= tls_sat(reg_wdata);
        `TLS_ADDR_INT_REV:   int_rev   <= tls_sat(reg_wdata);
        `TLS_ADDR_EXT_FWD:   ext_fwd   <= tls_sat(reg_wdata);
        `TLS_ADDR_EXT_REV:   ext_rev   <= tls_sat(reg_wdata);
        `TLS_ADDR_LIN_FWD:   lin_fwd   <= tls_sat(reg_wdata);
        `TLS_ADDR_LIN_REV:   lin_rev   <= tls_sat(reg_wdata);
        `TLS_ADDR_FILT_TC:   filt_tc   <= reg_wdata[15:0];
        `TLS_ADDR_PIN_ALLOC: pin_alloc <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Source select only moves at a setup restart, never mid-run
  always_ff @(posedge mclk) begin
    if (rst)                                          src_act <= TLS_SRC_INTERNAL;
    else if (reg_wr && reg_addr == `TLS_ADDR_APPLY)   src_act <= src_pend;
  end

  // External-limit inputs from their allocated pins; codes 8..15 mean never on
  tls_pin_sync u_pin_sync (
    .mclk   (mclk),
    .rst    (rst),
    .pins   (input_pins),
    .pins_s (pins_s)
  );
  assign fwd_pin = pin_alloc[`TLS_ALLOC_FWD_LSB +: 4];
  assign rev_pin = pin_alloc[`TLS_ALLOC_REV_LSB +: 4];
  assign fwd_on  = ~fwd_pin[3] & pins_s[fwd_pin[2:0]];
  assign rev_on  = ~rev_pin[3] & pins_s[rev_pin[2:0]];

  // Converter word registered once before filtering
  always_ff @(posedge mclk) begin
    if (rst) analog_q <= 16'sh0000;
    else     analog_q <= analog_cmd;
  end

  tls_cmd_filter u_cmd_filter (
    .mclk     (mclk),
    .rst      (rst),
    .raw      (analog_q),
    .tc       (filt_tc),
    .filtered (filtered)
  );

  // Gain times 0.1 V gives rated torque: percent = millivolts / gain
  always_comb begin
    abs_mv  = filtered[15] ? 16'(-filtered) : 16'(filtered);
    quot    = abs_mv / {9'h000, gain};
    ana_pct = (quot > 16'(`TLS_PCT_MAX)) ? `TLS_PCT_MAX : quot[9:0];
  end

  // Torque mode owns the analog input, so it cannot limit there
  assign ana_ok = ~cfg_tq;

  // Linear motor swaps in its own internal limits
  assign sel_fwd = cfg_linear ? lin_fwd : int_fwd;
  assign sel_rev = cfg_linear ? lin_rev : int_rev;

  // Per-direction selection
  always_comb begin
    next_limits.fwd = tls_pick(src_act, fwd_on, ana_ok, sel_fwd, ext_fwd, ana_pct);
    next_limits.rev = tls_pick(src_act, rev_on, ana_ok, sel_rev, ext_rev, ana_pct);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      active_limits.fwd <= `TLS_INT_LIMIT_RST;
      active_limits.rev <= `TLS_INT_LIMIT_RST;
    end else begin
      active_limits <= next_limits;
    end
  end

  // Torque at or past the limit of its direction counts as limited
  assign next_detected = torque_fb_rev ? (torque_fb_pct >= active_limits.rev)
                                       : (torque_fb_pct >= active_limits.fwd);
  always_ff @(posedge mclk) begin
    if (rst) limit_detected_output <= 1'b0;
    else     limit_detected_output <= next_detected;
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      unique case (reg_addr)
        `TLS_ADDR_SRC_SEL:   reg_rdata <= {30'h0, src_pend};
        `TLS_ADDR_CFG:       reg_rdata <= {30'h0, cfg_tq, cfg_linear};
        `TLS_ADDR_GAIN:      reg_rdata <= {25'h0, gain};
        `TLS_ADDR_INT_FWD:   reg_rdata <= {22'h0, int_fwd};
        `TLS_ADDR_INT_REV:   reg_rdata <= {22'h0, int_rev};
        `TLS_ADDR_EXT_FWD:   reg_rdata <= {22'h0, ext_fwd};
        `TLS_ADDR_EXT_REV:   reg_rdata <= {22'h0, ext_rev};
        `TLS_ADDR_LIN_FWD:   reg_rdata <= {22'h0, lin_fwd};
        `TLS_ADDR_LIN_REV:   reg_rdata <= {22'h0, lin_rev};
        `TLS_ADDR_FILT_TC:   reg_rdata <= {16'h0, filt_tc};
        `TLS_ADDR_PIN_ALLOC: reg_rdata <= {16'h0, pin_alloc};
        `TLS_ADDR_STATUS:    reg_rdata <= {27'h0, limit_detected_output, rev_on,
                                           fwd_on, src_act};
        `TLS_ADDR_ACTIVE:    reg_rdata <= {12'h0, active_limits.rev, active_limits.fwd};
        `TLS_ADDR_ANALOG:    reg_rdata <= {22'h0, ana_pct};
        default:             reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_src_write;
    reg_wr && reg_addr == `TLS_ADDR_SRC_SEL;
  endsequence
  sequence s_apply;
    reg_wr && reg_addr == `TLS_ADDR_APPLY;
  endsequence

  AST_SRC_WAITS_RESTART: assert property (
    s_src_write ##1 !(reg_wr && reg_addr == `TLS_ADDR_APPLY) |-> $stable(src_act))
    else $error("source select changed without restart");
  AST_SRC_APPLIED: assert property (
    s_apply |=> src_act == $past(src_pend))
    else $error("restart did not load source select");
  AST_ANALOG_ONLY_MIN: assert property (
    (src_act == TLS_SRC_ANALOG && ana_ok)
    |=> active_limits.fwd == tls_min($past(sel_fwd), $past(ana_pct)))
    else $error("analog mode forward limit not the minimum");
  AST_ROT_FWD_ON: assert property (
    (src_act == TLS_SRC_ANALOG_EXT && fwd_on && ana_ok && !cfg_linear)
    |=> active_limits.fwd <= $past(int_fwd) && active_limits.fwd <= $past(ext_fwd)
        && active_limits.fwd <= $past(ana_pct))
    else $error("rotary forward combined limit too high");
  AST_ROT_FWD_OFF: assert property (
    (src_act != TLS_SRC_ANALOG && !fwd_on && !cfg_linear)
    |=> active_limits.fwd == $past(int_fwd))
    else $error("rotary forward limit not internal");
  AST_ROT_REV_ON: assert property (
    (src_act == TLS_SRC_ANALOG_EXT && rev_on && ana_ok && !cfg_linear)
    |=> active_limits.rev <= $past(int_rev) && active_limits.rev <= $past(ext_rev)
        && active_limits.rev <= $past(ana_pct))
    else $error("rotary reverse combined limit too high");
  AST_ROT_REV_OFF: assert property (
    (src_act != TLS_SRC_ANALOG && !rev_on && !cfg_linear)
    |=> active_limits.rev == $past(int_rev))
    else $error("rotary reverse limit not internal");
  AST_LIN_FWD_ON: assert property (
    (src_act == TLS_SRC_ANALOG_EXT && fwd_on && ana_ok && cfg_linear)
    |=> active_limits.fwd == tls_min(tls_min($past(lin_fwd), $past(ext_fwd)),
                                     $past(ana_pct)))
    else $error("linear forward combined limit wrong");
  AST_LIN_FWD_OFF: assert property (
    (src_act != TLS_SRC_ANALOG && !fwd_on && cfg_linear)
    |=> active_limits.fwd == $past(lin_fwd))
    else $error("linear forward limit not internal");
  AST_LIN_REV_ON: assert property (
    (src_act == TLS_SRC_ANALOG_EXT && rev_on && ana_ok && cfg_linear)
    |=> active_limits.rev == tls_min(tls_min($past(lin_rev), $past(ext_rev)),
                                     $past(ana_pct)))
    else $error("linear reverse combined limit wrong");
  AST_LIN_REV_OFF: assert property (
    (src_act != TLS_SRC_ANALOG && !rev_on && cfg_linear)
    |=> active_limits.rev == $past(lin_rev))
    else $error("linear reverse limit not internal");
  AST_TQ_NO_ANALOG: assert property (
    (cfg_tq && src_act == TLS_SRC_ANALOG) |=> active_limits.fwd == $past(sel_fwd))
    else $error("analog limit used in torque mode");
  AST_LIMIT_RANGE: assert property (
    active_limits.fwd <= `TLS_PCT_MAX && active_limits.rev <= `TLS_PCT_MAX
    && gain >= `TLS_GAIN_MIN && gain <= `TLS_GAIN_MAX)
    else $error("limit or gain out of range");
  AST_DETECT_CAUSE: assert property (
    limit_detected_output |-> $past(torque_fb_pct) >=
      ($past(torque_fb_rev) ? $past(active_limits.rev) : $past(active_limits.fwd)))
    else $error("limit detected without torque at limit");

endmodule : tls_torque_limit_selector

// File: verilog/tls_params.svh
// Constants of the torque limit selector: register indices, fields, resets, timing
`ifndef TLS_PARAMS_SVH
`define TLS_PARAMS_SVH

// Register indices on the plain register port
`define TLS_ADDR_SRC_SEL    4'h0
`define TLS_ADDR_CFG        4'h1
`define TLS_ADDR_GAIN       4'h2
`define TLS_ADDR_INT_FWD    4'h3
`define TLS_ADDR_INT_REV    4'h4
`define TLS_ADDR_EXT_FWD    4'h5
`define TLS_ADDR_EXT_REV    4'h6
`define TLS_ADDR_LIN_FWD    4'h7
`define TLS_ADDR_LIN_REV    4'h8
`define TLS_ADDR_FILT_TC    4'h9
`define TLS_ADDR_PIN_ALLOC  4'ha
`define TLS_ADDR_APPLY      4'hb
`define TLS_ADDR_STATUS     4'hc
`define TLS_ADDR_ACTIVE     4'hd
`define TLS_ADDR_ANALOG     4'he

// Field positions
`define TLS_CFG_LINEAR_BIT  0
`define TLS_CFG_TQMODE_BIT  1
`define TLS_ALLOC_FWD_LSB   4
`define TLS_ALLOC_REV_LSB   8

// Reset values and ranges
`define TLS_PCT_MAX         10'h320
`define TLS_INT_LIMIT_RST   10'h320
`define TLS_EXT_LIMIT_RST   10'h064
`define TLS_LIN_LIMIT_RST   10'h01e
`define TLS_GAIN_RST        7'h1e
`define TLS_GAIN_MIN        7'h0a
`define TLS_GAIN_MAX        7'h64
`define TLS_TC_RST          16'h0000
`define TLS_PIN_ALLOC_RST   16'h0540
`define TLS_PIN_COUNT       8

// Filter time unit 0.01 ms, clock period 100 ns
`define TLS_TC_UNIT_NS      10000
`define TLS_CLK_PERIOD_NS   100
`define TLS_TICK_CYCLES     (`TLS_TC_UNIT_NS / `TLS_CLK_PERIOD_NS)

`endif

// File: verilog/tls_pkg.sv
// Types shared by the torque limit selector files
package tls_pkg;

  // Torque in percent of rated torque, 0..800
  typedef logic [9:0] tls_pct_t;

  // Limit source selection
  typedef enum logic [1:0] {
    TLS_SRC_INTERNAL   = 2'b00,
    TLS_SRC_ANALOG     = 2'b01,
    TLS_SRC_RESERVED   = 2'b10,
    TLS_SRC_ANALOG_EXT = 2'b11
  } tls_src_t;

  // Forward and reverse limit pair
  typedef struct packed {
    tls_pct_t rev;
    tls_pct_t fwd;
  } tls_limit_pair_t;

endpackage : tls_pkg

// File: verilog/tls_pin_sync.sv
// Two-stage synchroniser for the digital input pins
`timescale 1ns/100ps
`include "tls_params.svh"

module tls_pin_sync (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // Pins and synchronised copy
  input  wire logic [`TLS_PIN_COUNT-1:0]   pins,
  output logic      [`TLS_PIN_COUNT-1:0]   pins_s
);
  logic [`TLS_PIN_COUNT-1:0] meta;

  // One chain per pin; first stage feeds only the second
  for (genvar i = 0; i < `TLS_PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (rst) begin
        meta[i]   <= 1'b0;
        pins_s[i] <= 1'b0;
      end else begin
        meta[i]   <= pins[i];
        pins_s[i] <= meta[i];
      end
    end
  end

endmodule : tls_pin_sync

// File: verilog/tls_cmd_filter.sv
// First-order low-pass filter for the analog torque command
`timescale 1ns/100ps
`include "tls_params.svh"

module tls_cmd_filter (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // Raw command and time constant in 0.01 ms
  input  wire logic signed [15:0] raw,
  input  wire logic        [15:0] tc,
  // Filtered command
  output logic signed      [15:0] filtered
);
  logic        [6:0]  tick_cnt;
  logic               tick;
  logic signed [17:0] diff;
  logic signed [17:0] step;
  logic signed [17:0] next_sum;

  // One step per time unit, so the tc figure is the time constant
  always_ff @(posedge mclk) begin
    if (rst || tick) tick_cnt <= 7'h00;
    else             tick_cnt <= tick_cnt + 7'h01;
  end
  assign tick = (tick_cnt == 7'(`TLS_TICK_CYCLES - 1));

  // Truncating divide leaves an error below tc counts; fine for a limit
  always_comb begin
    diff     = {{2{raw[15]}}, raw} - {{2{filtered[15]}}, filtered};
    step     = diff / $signed({2'b00, tc});
    next_sum = {{2{filtered[15]}}, filtered} + step;
  end

  // Zero time constant passes the command straight through
  always_ff @(posedge mclk) begin
    if (rst)                  filtered <= 16'sh0000;
    else if (tc == 16'h0000)  filtered <= raw;
    else if (tick)            filtered <= next_sum[15:0];
  end

endmodule : tls_cmd_filter

// File: tb/tls_host_model.sv
// Host controller model: drives the external-limit pins and the analog command
`timescale 1ns/100ps

module tls_host_model (
  // Clock
  input  wire logic               mclk,
  // Requested levels and pin codes
  input  wire logic               fwd_on,
  input  wire logic               rev_on,
  input  wire logic        [3:0]  fwd_code,
  input  wire logic        [3:0]  rev_code,
  input  wire logic signed [15:0] cmd_mv,
  // Toward the drive
  output logic             [7:0]  input_pins,
  output logic signed      [15:0] analog_cmd
);
  logic [7:0] next_pins;

  // Codes 8..15 reach no pin, so such an input is never seen
  always_comb begin
    next_pins = 8'h00;
    if (fwd_on && !fwd_code[3]) next_pins[fwd_code[2:0]] = 1'b1;
    if (rev_on && !rev_code[3]) next_pins[rev_code[2:0]] = 1'b1;
  end

  // Levels change just after the edge, like a real controller output
  initial begin
    input_pins = 8'h00;
    analog_cmd = 16'sh0000;
  end
  always @(posedge mclk) begin
    input_pins <= next_pins;
    analog_cmd <= cmd_mv;
  end
endmodule : tls_host_model

// File: tb/tb_torque_limit_selector.sv
// Self-checking bench of the torque limit selector
`timescale 1ns/100ps
`include "tls_params.svh"

module tb_torque_limit_selector;
  import tls_pkg::*;
  // Clock, reset and register port
  logic                  mclk, rst, reg_wr, reg_rd;
  logic           [3:0]  reg_addr;
  logic           [31:0] reg_wdata, reg_rdata;
  // Far side and results
  logic                  fwd_on, rev_on, lim_det, fb_rev;
  logic signed    [15:0] cmd_mv, analog_cmd;
  logic           [7:0]  input_pins;
  logic           [15:0] seed;
  tls_pct_t              fb_pct;
  tls_limit_pair_t       lims;
  // Reference model state, indexed by register
  int                    rv[16];
  int                    src_act, miscompares, total_checks;

  tls_torque_limit_selector dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_pins(input_pins), .analog_cmd(analog_cmd), .torque_fb_pct(fb_pct),
    .torque_fb_rev(fb_rev), .active_limits(lims), .limit_detected_output(lim_det));
  tls_host_model host_u (.mclk(mclk), .fwd_on(fwd_on), .rev_on(rev_on),
    .fwd_code(4'(rv[10] >> 4)), .rev_code(4'(rv[10] >> 8)), .cmd_mv(cmd_mv),
    .input_pins(input_pins), .analog_cmd(analog_cmd));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Register write; the model mirrors the clamping of the drive
  task automatic wr(input logic [3:0] a, input int d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= 32'(d);
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a == `TLS_ADDR_APPLY) src_act = rv[0];
    else if (a == `TLS_ADDR_GAIN) rv[2] = d < 10 ? 10 : (d > 100 ? 100 : d);
    else if (a >= 3 && a <= 8) rv[a] = d > 800 ? 800 : d;
    else rv[a] = d;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input int e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 32'(e));
  endtask : rd_chk

  function automatic int mn(input int a, input int b);
    return a < b ? a : b;
  endfunction : mn

  // Command in percent: gain times 0.1 V is rated torque
  function automatic int ana_pct();
    int m;
    m = cmd_mv < 0 ? -int'(cmd_mv) : int'(cmd_mv);
    m = m / rv[2];
    return m > 800 ? 800 : m;
  endfunction : ana_pct

  // Expected limit, r = 0 forward, 1 reverse
  function automatic int exp_lim(input int r);
    int il, c;
    bit on;
    il = (rv[1] & 1) ? rv[7 + r] : rv[3 + r];
    c = (rv[10] >> (4 + 4 * r)) & 15;
    on = (c < 8) && (r ? rev_on : fwd_on);
    if (src_act == 1) return (rv[1] & 2) ? il : mn(il, ana_pct());
    if (!on || src_act == 2) return il;
    if (src_act == 0 || (rv[1] & 2)) return mn(il, rv[5 + r]);
    return mn(mn(il, rv[5 + r]), ana_pct());
  endfunction : exp_lim

  // Let pins and command settle, compare limits, then probe detection
  task automatic chk_lims();
    int f, r;
    repeat (6) @(posedge mclk);
    #1;
    f = exp_lim(0);
    r = exp_lim(1);
    chk(32'(lims.fwd), 32'(f));
    chk(32'(lims.rev), 32'(r));
    @(posedge mclk);
    fb_pct <= 10'(f);
    fb_rev <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(32'(lim_det), 32'h1);
    @(posedge mclk);
    fb_pct <= 10'(r == 0 ? 0 : r - 1);
    fb_rev <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(32'(lim_det), 32'(r == 0));
  endtask : chk_lims

  // Hang guard
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    {fwd_on, rev_on, fb_rev} = 3'h0;
    cmd_mv = 16'sh0000;
    fb_pct = 10'h000;
    seed = 16'h0039;
    miscompares = 0;
    total_checks = 0;
    src_act = 0;
    foreach (rv[i]) rv[i] = 0;
    rv[2] = 30;
    rv[3] = 800;
    rv[4] = 800;
    rv[5] = 100;
    rv[6] = 100;
    rv[7] = 30;
    rv[8] = 30;
    rv[10] = 'h540;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, then an unmapped index
    for (int a = 0; a <= 10; a++) rd_chk(4'(a), rv[a]);
    rd_chk(4'hf, 0);
    wr(`TLS_ADDR_GAIN, 5);
    rd_chk(`TLS_ADDR_GAIN, rv[2]);
    wr(`TLS_ADDR_GAIN, 200);
    rd_chk(`TLS_ADDR_GAIN, rv[2]);
    wr(`TLS_ADDR_GAIN, 30);
    chk_lims();
    $display("test reset and gain done");
    // Source 3 staged but not applied: still internal and external only
    wr(`TLS_ADDR_SRC_SEL, 3);
    wr(`TLS_ADDR_INT_FWD, 500);
    wr(`TLS_ADDR_EXT_FWD, 300);
    wr(`TLS_ADDR_INT_REV, 250);
    wr(`TLS_ADDR_EXT_REV, 400);
    cmd_mv <= 16'sd6000;
    fwd_on <= 1'b1;
    rev_on <= 1'b1;
    chk_lims();
    wr(`TLS_ADDR_APPLY, 1);
    chk_lims();
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      cmd_mv <= seed;
      fwd_on <= seed[3];
      rev_on <= seed[9];
      chk_lims();
    end
    $display("test rotary combined done");
    // Linear motor, all four input combinations
    wr(`TLS_ADDR_CFG, 1);
    wr(`TLS_ADDR_LIN_FWD, 150);
    wr(`TLS_ADDR_LIN_REV, 20);
    cmd_mv <= -16'sd6000;
    for (int i = 0; i < 4; i++) begin
      fwd_on <= i[0];
      rev_on <= i[1];
      chk_lims();
    end
    wr(`TLS_ADDR_CFG, 2);
    chk_lims();
    $display("test linear and torque mode done");
    // Forward input moved to pin 2, then a code that reaches no pin
    wr(`TLS_ADDR_CFG, 0);
    wr(`TLS_ADDR_PIN_ALLOC, 'h0520);
    chk_lims();
    wr(`TLS_ADDR_PIN_ALLOC, 'h0580);
    chk_lims();
    // Analog only, then torque mode takes the analog input away
    wr(`TLS_ADDR_SRC_SEL, 1);
    wr(`TLS_ADDR_APPLY, 1);
    fwd_on <= 1'b0;
    rev_on <= 1'b0;
    chk_lims();
    wr(`TLS_ADDR_CFG, 2);
    chk_lims();
    wr(`TLS_ADDR_CFG, 0);
    // One time unit of filtering settles within one tick of 100 cycles
    wr(`TLS_ADDR_FILT_TC, 1);
    cmd_mv <= 16'sd3000;
    repeat (110) @(posedge mclk);
    chk_lims();
    // Status, active pair and analog percent seen on the register port
    rd_chk(`TLS_ADDR_ACTIVE, (exp_lim(1) << 10) | exp_lim(0));
    rd_chk(`TLS_ADDR_ANALOG, ana_pct());
    rd_chk(`TLS_ADDR_STATUS, src_act);
    $display("test pin allocation, analog only and filter done");
    stop_test();
  end
endmodule : tb_torque_limit_selector
